/* File: pkg/gim_pkg.sv */
// Shared constants, register map and state types of the bus interface message handler.
// Assumes a single 10 MHz system clock and an Avalon-MM master with waitrequest.
package gim_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned RTL_TIMEOUT_MS = 7500;
  localparam int unsigned RTL_TIMEOUT_CYC = RTL_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned RTL_CNT_W = 27;

  // ----------------------------------------------------------------
  // Multiline interface command codes (seven bits, with ATN)
  // ----------------------------------------------------------------
  localparam logic [6:0] CODE_GTL = 7'h01;
  localparam logic [6:0] CODE_SDC = 7'h04;
  localparam logic [6:0] CODE_GET = 7'h08;
  localparam logic [6:0] CODE_LLO = 7'h11;
  localparam logic [6:0] CODE_DCL = 7'h14;
  localparam logic [6:0] CODE_SPE = 7'h18;
  localparam logic [6:0] CODE_SPD = 7'h19;
  localparam logic [6:0] CODE_UNL = 7'h3f;
  localparam logic [6:0] CODE_UNT = 7'h5f;
  localparam logic [6:0] LISTEN_BASE = 7'h20;
  localparam logic [6:0] TALK_BASE = 7'h40;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_POLL_BYTE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int unsigned CFG_ADDR_LSB = 0;
  localparam int unsigned CFG_MODE_LSB = 5;
  localparam int unsigned CFG_SRC_BUS = 7;
  localparam logic [4:0] RST_PRIM_ADDR = 5'h0a;
  localparam logic [7:0] RST_POLL_BYTE = 8'h00;

  // Trigger modes held in the configuration register.
  typedef enum logic [1:0] {
    single_triggered_mode = 2'h0,
    free_running_mode = 2'h1,
    burst_mode = 2'h2,
    gated_mode = 2'h3
  } gim_single_triggered_mode_e;

  // Remote/local machine, Gray coded around the usual loop.
  typedef enum logic [1:0] {
    local_state = 2'h0,
    remote_state = 2'h1,
    remote_lockout_state = 2'h3,
    local_lockout_state = 2'h2
  } gim_rl_e;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } gim_av_req_s;

  // Complete state of the handler.
  typedef struct packed {
    logic talker;
    logic listener;
    logic spoll;
    gim_rl_e rl;
    logic rtl;
    logic [RTL_CNT_W-1:0] rtl_cnt;
    logic waitreq;
    logic [31:0] rdata;
    logic [4:0] prim_addr;
    gim_single_triggered_mode_e single_triggered_mode_mode;
    logic single_triggered_mode_bus;
    logic [7:0] poll_byte;
    logic dev_clear;
    logic trigger;
    logic rtl_error;
    logic cmd_exec;
    logic cmd_error;
    logic talk_valid;
    logic [7:0] talk_byte;
    logic addr_ind;
    logic remote_ind;
    logic srq;
  } gim_state_s;

endpackage : gim_pkg

/* File: core/gim_handler.sv */
// Instrument-side handler for bus interface messages and the remote/local machine.
// Assumes the acceptor handshake delivers one strobe per received byte, all inputs are
// synchronous to clk, and the register master is Avalon-MM with waitrequest.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.

module gim_handler
  import gim_pkg::*;
#(
  parameter int unsigned RTL_TIMEOUT_CYCLES = RTL_TIMEOUT_CYC
) (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire gim_av_req_s av_req, // Avalon-MM request group.
  output logic [31:0] av_readdata, // Avalon-MM read data.
  output logic av_waitrequest, // Avalon-MM wait request.
  input wire logic bus_atn, // Attention line, high when asserted.
  input wire logic bus_ifc, // Interface clear line, high when asserted.
  input wire logic bus_ren, // Remote enable line, high when asserted.
  input wire logic rx_strobe, // One pulse per byte accepted from the bus.
  input wire logic [7:0] rx_byte, // Byte accepted from the bus.
  input wire logic dev_cmd_valid, // Parsed device command ready to run.
  input wire logic dev_cmd_query, // That command is a query.
  input wire logic dev_pending, // Unexecuted settings or commands exist.
  input wire logic fp_setting_key, // Setting-changing front-panel key pressed.
  input wire logic fp_entry_done, // Front-panel entry executed.
  input wire logic talk_req, // Source handshake wants the next byte.
  input wire logic [7:0] outbuf_byte, // Next byte of the output buffer.
  output logic talk_valid, // Pulse: talk_byte is to be sent.
  output logic [7:0] talk_byte, // Byte offered to the source handshake.
  output logic talker_active, // Talker is addressed.
  output logic listener_active, // Listener is addressed.
  output logic dev_clear, // Pulse: flush buffers and unexecuted settings.
  output logic dev_trigger, // Pulse: bus trigger.
  output logic cmd_exec, // Pulse: run the offered command.
  output logic cmd_error, // Pulse: offered command refused.
  output logic rtl_error, // Pulse: return-to-local cut off pending work.
  output logic addressed_indicator, // Address lamp.
  output logic remote_indicator, // Remote lamp.
  output logic srq // Service request line drive, high to assert.
);

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  gim_state_s st;
  gim_state_s next_st;

  // Decoded view of the received byte, the configuration and the Avalon request.
  logic is_cmd;
  logic [6:0] code;
  logic [6:0] my_listen;
  logic [6:0] my_talk;
  logic single_triggered_mode_enabled;
  logic to_remote;
  logic go_local;
  logic lockout;
  logic av_take;

  // ----------------------------------------------------------------
  // Command decode helpers
  // ----------------------------------------------------------------
  // The eighth data bit carries parity on some controllers, so it is dropped.
  assign is_cmd = rx_strobe & bus_atn;
  assign code = rx_byte[6:0];
  assign my_listen = LISTEN_BASE + {2'h0, st.prim_addr};
  assign my_talk = TALK_BASE + {2'h0, st.prim_addr};
  // Bus trigger needs one of the three triggering modes and the bus as source.
  assign single_triggered_mode_enabled = st.single_triggered_mode_bus & (st.single_triggered_mode_mode != gated_mode);
  assign to_remote = is_cmd & bus_ren & (code == my_listen);
  assign go_local = is_cmd & st.listener & (code == CODE_GTL);
  assign lockout = is_cmd & st.listener & bus_ren & (code == CODE_LLO);
  // A request is served at the edge where waitrequest has been low for a cycle.
  assign av_take = (av_req.read | av_req.write) & ~st.waitreq;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One pass computes the whole next state; pulses default low each cycle.
  always_comb begin
    next_st = st;
    next_st.dev_clear = 1'b0;
    next_st.trigger = 1'b0;
    next_st.rtl_error = 1'b0;
    next_st.cmd_exec = 1'b0;
    next_st.cmd_error = 1'b0;
    next_st.talk_valid = 1'b0;

    // Addressing.  Unlisten is checked first so an address of 31 cannot alias it.
    if (is_cmd) begin
      if (code == CODE_UNL) begin
        next_st.listener = 1'b0;
      end else if (code == CODE_UNT) begin
        next_st.talker = 1'b0;
      end else if (code == my_listen) begin
        next_st.listener = 1'b1;
        next_st.talker = 1'b0;
      end else if (code == my_talk) begin
        next_st.talker = 1'b1;
        next_st.listener = 1'b0;
      end
    end

    // Universal commands and addressed commands.  Poll configure codes fall through
    // untouched because this device takes no part in parallel poll.
    if (is_cmd) begin
      case (code)
        CODE_DCL: begin
          next_st.dev_clear = 1'b1;
          next_st.spoll = 1'b0;
        end
        CODE_SDC: begin
          next_st.dev_clear = st.listener;
        end
        CODE_GET: begin
          next_st.trigger = st.listener & single_triggered_mode_enabled;
        end
        CODE_SPE: begin
          next_st.spoll = 1'b1;
        end
        CODE_SPD: begin
          next_st.spoll = 1'b0;
        end
        default: begin
          next_st.spoll = next_st.spoll;
        end
      endcase
    end

    // Interface clear overrides any addressing in the same cycle.
    if (bus_ifc) begin
      next_st.talker = 1'b0;
      next_st.listener = 1'b0;
      next_st.spoll = 1'b0;
    end

    // Return-to-local request from the front panel.  Remote-lockout never sees it.
    if (fp_setting_key && st.rl != remote_lockout_state) begin
      next_st.rtl = 1'b1;
      next_st.rtl_cnt = '0;
    end else if (st.rtl) begin
      if (fp_entry_done || st.rtl_cnt == RTL_CNT_W'(RTL_TIMEOUT_CYCLES - 1)) begin
        next_st.rtl = 1'b0;
        next_st.rtl_cnt = '0;
      end else begin
        next_st.rtl_cnt = st.rtl_cnt + 1'b1;
      end
    end

    // Remote/local machine.  Remote enable low wins over everything.
    case (st.rl)
      local_state: begin
        if (lockout) begin
          next_st.rl = local_lockout_state;
        end else if (to_remote && !st.rtl) begin
          next_st.rl = remote_state;
        end
      end
      remote_state: begin
        if (lockout) begin
          next_st.rl = remote_lockout_state;
        end else if (go_local) begin
          next_st.rl = local_state;
        end else if (fp_setting_key) begin
          next_st.rl = local_state;
          next_st.rtl_error = dev_pending;
        end
      end
      remote_lockout_state: begin
        if (go_local) begin
          next_st.rl = local_lockout_state;
        end
      end
      local_lockout_state: begin
        if (to_remote) begin
          next_st.rl = remote_lockout_state;
        end
      end
      default: begin
        next_st.rl = local_state;
      end
    endcase
    if (!bus_ren) begin
      next_st.rl = local_state;
    end

    // Device commands need an addressed listener; local states run queries only.
    if (dev_cmd_valid && st.listener) begin
      if (!dev_cmd_query && (st.rl == local_state || st.rl == local_lockout_state)) begin
        next_st.cmd_error = 1'b1;
      end else begin
        next_st.cmd_exec = 1'b1;
      end
    end

    // Talker data: poll byte in poll mode, output buffer otherwise.  Cleared or
    // unaddressed talkers never offer a byte.
    if (talk_req && st.talker && !bus_atn && !bus_ifc) begin
      next_st.talk_valid = 1'b1;
      next_st.talk_byte = st.spoll ? st.poll_byte : outbuf_byte;
    end

    // Indicators follow the next state so they change together with it.
    next_st.addr_ind = next_st.talker | next_st.listener;
    next_st.remote_ind = (next_st.rl == remote_state) | (next_st.rl == remote_lockout_state);
    // Service request follows the request bit of the poll byte.
    next_st.srq = st.poll_byte[6];

    // Avalon slave: drop waitrequest one cycle after a request arrives, act at
    // the edge that sees it low, then raise it again.  Costs one wait state.
    if (av_take) begin
      next_st.waitreq = 1'b1;
      if (av_req.write && av_req.byteenable[0]) begin
        if (av_req.address == REG_CONFIG) begin
          next_st.prim_addr = av_req.writedata[CFG_ADDR_LSB +: 5];
          next_st.single_triggered_mode_mode = gim_single_triggered_mode_e'(av_req.writedata[CFG_MODE_LSB +: 2]);
          next_st.single_triggered_mode_bus = av_req.writedata[CFG_SRC_BUS];
        end else if (av_req.address == REG_POLL_BYTE) begin
          next_st.poll_byte = av_req.writedata[7:0];
        end
      end
    end else if (av_req.read || av_req.write) begin
      next_st.waitreq = 1'b0;
      case (av_req.address)
        REG_CONFIG: begin
          next_st.rdata = {24'h0, st.single_triggered_mode_bus, st.single_triggered_mode_mode, st.prim_addr};
        end
        REG_POLL_BYTE: begin
          next_st.rdata = {24'h0, st.poll_byte};
        end
        REG_STATUS: begin
          next_st.rdata = {26'h0, st.rl, st.rtl, st.spoll, st.listener, st.talker};
        end
        default: begin
          next_st.rdata = 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State flip-flops
  // ----------------------------------------------------------------
  // Reset leaves the device unaddressed, local and with a neutral configuration.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.rl <= local_state;
      st.prim_addr <= RST_PRIM_ADDR;
      st.single_triggered_mode_mode <= single_triggered_mode;
      st.poll_byte <= RST_POLL_BYTE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from the state flops
  // ----------------------------------------------------------------
  assign av_readdata = st.rdata;
  assign av_waitrequest = st.waitreq;
  assign talk_valid = st.talk_valid;
  assign talk_byte = st.talk_byte;
  assign talker_active = st.talker;
  assign listener_active = st.listener;
  assign dev_clear = st.dev_clear;
  assign dev_trigger = st.trigger;
  assign cmd_exec = st.cmd_exec;
  assign cmd_error = st.cmd_error;
  assign rtl_error = st.rtl_error;
  assign addressed_indicator = st.addr_ind;
  assign remote_indicator = st.remote_ind;
  assign srq = st.srq;

endmodule : gim_handler

/* File: dv/gim_checker.sv */
// Assertions on the ports of the interface message handler, bound to its top module.
// Assumes every input is synchronous to clk and reset is asynchronous, active low.
module gim_checker
  import gim_pkg::*;
#(
  parameter int unsigned RTL_TIMEOUT_CYCLES = 50
) (
  input wire logic clk, // Clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic bus_atn, // Attention.
  input wire logic bus_ifc, // Interface clear.
  input wire logic bus_ren, // Remote enable.
  input wire logic rx_strobe, // Byte strobe.
  input wire logic [7:0] rx_byte, // Received byte.
  input wire logic dev_cmd_valid, // Command offer.
  input wire logic talk_valid, // Talker byte pulse.
  input wire logic talker_active, // Talker addressed.
  input wire logic listener_active, // Listener addressed.
  input wire logic dev_clear, // Clear pulse.
  input wire logic dev_trigger, // Trigger pulse.
  input wire logic cmd_exec, // Command run.
  input wire logic cmd_error, // Command refused.
  input wire logic addressed_indicator, // Address lamp.
  input wire logic remote_indicator // Remote lamp.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // All checks share one clock and are dropped while reset is low.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_code(logic [6:0] c);
    rx_strobe && bus_atn && rx_byte[6:0] == c;
  endsequence
  unl_idle_a:
    assert property (s_code(CODE_UNL) |=> !listener_active) else $error("Listener kept after unlisten.");
  unt_idle_a:
    assert property (s_code(CODE_UNT) |=> !talker_active) else $error("Talker kept after untalk.");
  talk_quiet_a:
    assert property (talk_valid |-> $past(talker_active)) else $error("Byte sent by an idle talker.");
  addr_lamp_a:
    assert property (addressed_indicator == (talker_active || listener_active)) else $error("Address lamp wrong.");
  ifc_idle_a:
    assert property (bus_ifc |=> !talker_active && !listener_active) else $error("Clear left a function addressed.");
  dcl_pulse_a:
    assert property (s_code(CODE_DCL) |=> dev_clear) else $error("Device clear not pulsed.");
  clear_cause_a:
    assert property (dev_clear |-> $past(rx_strobe && bus_atn && (rx_byte[6:0] == CODE_DCL
      || (rx_byte[6:0] == CODE_SDC && listener_active)))) else $error("Clear without a valid cause.");
  single_triggered_mode_cause_a:
    assert property (dev_trigger |-> $past(rx_strobe && bus_atn && rx_byte[6:0] == CODE_GET && listener_active))
      else $error("Trigger without a valid cause.");
  ren_local_a:
    assert property (!bus_ren |=> !remote_indicator) else $error("Remote lamp lit without remote enable.");
  cmd_answer_a:
    assert property (dev_cmd_valid && listener_active |=> cmd_exec != cmd_error) else $error("Command unanswered.");
  atn_gate_a:
    assert property (rx_strobe && !bus_atn && !bus_ifc |=> $stable(talker_active) && $stable(listener_active))
      else $error("Data byte changed addressing.");
endmodule : gim_checker

bind gim_handler gim_checker #(.RTL_TIMEOUT_CYCLES(RTL_TIMEOUT_CYCLES)) chk_u (
  .clk(clk), .arst_n(arst_n), .bus_atn(bus_atn), .bus_ifc(bus_ifc), .bus_ren(bus_ren),
  .rx_strobe(rx_strobe), .rx_byte(rx_byte), .dev_cmd_valid(dev_cmd_valid), .talk_valid(talk_valid),
  .talker_active(talker_active), .listener_active(listener_active), .dev_clear(dev_clear),
  .dev_trigger(dev_trigger), .cmd_exec(cmd_exec), .cmd_error(cmd_error),
  .addressed_indicator(addressed_indicator), .remote_indicator(remote_indicator)
);

/* File: dv/gim_ctrl_model.sv */
// Behavioural controller in charge that drives the bus lines of the handler.
// Assumes its tasks are called from one bench process clocked on clk.
module gim_ctrl_model (
  input wire logic clk, // System clock.
  output logic bus_atn, // Attention line.
  output logic bus_ifc, // Interface clear line.
  output logic bus_ren, // Remote enable line.
  output logic rx_strobe, // Byte strobe.
  output logic [7:0] rx_byte // Data lines.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Remote enable is normally held true by the controller.
  initial begin
    bus_atn = 1'b0;
    bus_ifc = 1'b0;
    bus_ren = 1'b1;
    rx_strobe = 1'b0;
    rx_byte = 8'hff;
  end
  // One byte for one edge; afterwards the lines show the inverse so a stale byte is never reused.
  task send(input logic [7:0] b, input logic atn);
    @(posedge clk);
    bus_atn <= atn;
    rx_strobe <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
    bus_atn <= 1'b0;
    rx_strobe <= 1'b0;
    rx_byte <= ~b;
  endtask : send
  // Clear is held 1000 cycles, which is 100 us at 10 MHz.
  task pulse_ifc();
    @(posedge clk);
    bus_ifc <= 1'b1;
    repeat (1000) @(posedge clk);
    bus_ifc <= 1'b0;
  endtask : pulse_ifc
  task set_ren(input logic v);
    @(posedge clk);
    bus_ren <= v;
  endtask : set_ren
endmodule : gim_ctrl_model

/* File: dv/testbench.sv */
// Self-checking bench for the interface message handler and its remote/local machine.
// Assumes gim_ctrl_model stands in for the controller and a short rtl timeout is used.
module testbench
  import gim_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TMO = 50;
  localparam logic [7:0] MLA = 8'h2a;
  localparam logic [7:0] MTA = 8'h4a;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  gim_av_req_s av_req = '0;
  logic [31:0] av_readdata, q;
  logic av_waitrequest, bus_atn, bus_ifc, bus_ren, rx_strobe, talk_valid, talker_active, listener_active;
  logic [7:0] rx_byte, talk_byte;
  logic dev_clear, dev_trigger, cmd_exec, cmd_error, rtl_error, addressed_indicator, remote_indicator, srq;
  logic dev_cmd_valid = 1'b0, dev_cmd_query = 1'b0, dev_pending = 1'b0, talk_req = 1'b0;
  logic fp_setting_key = 1'b0, fp_entry_done = 1'b0;
  logic [7:0] outbuf_byte = 8'h00;
  int err_count = 0, n_compared = 0, cyc = 0;
  gim_handler #(.RTL_TIMEOUT_CYCLES(TMO)) dut_u (.clk(clk), .arst_n(arst_n), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .bus_atn(bus_atn), .bus_ifc(bus_ifc),
    .bus_ren(bus_ren), .rx_strobe(rx_strobe), .rx_byte(rx_byte), .dev_cmd_valid(dev_cmd_valid),
    .dev_cmd_query(dev_cmd_query), .dev_pending(dev_pending), .fp_setting_key(fp_setting_key),
    .fp_entry_done(fp_entry_done), .talk_req(talk_req), .outbuf_byte(outbuf_byte), .talk_valid(talk_valid),
    .talk_byte(talk_byte), .talker_active(talker_active), .listener_active(listener_active),
    .dev_clear(dev_clear), .dev_trigger(dev_trigger), .cmd_exec(cmd_exec), .cmd_error(cmd_error),
    .rtl_error(rtl_error), .addressed_indicator(addressed_indicator), .remote_indicator(remote_indicator),
    .srq(srq));
  gim_ctrl_model ctl_u (.clk(clk), .bus_atn(bus_atn), .bus_ifc(bus_ifc), .bus_ren(bus_ren),
    .rx_strobe(rx_strobe), .rx_byte(rx_byte));
  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  // The run needs about 1200 cycles; a hung handshake is cut off well after that.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  task test_done();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low; only the timeout ends the wait.
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    av_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do @(posedge clk); while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req <= '0;
  endtask : av
  // Expected status word; flags are given as small integers and cut to one bit on purpose.
  function automatic logic [31:0] stv(int t, int l, int r, logic [1:0] m);
    return {26'h0, m, 1'(r), 1'b0, 1'(l), 1'(t)};
  endfunction : stv
  // Pulse outputs are looked at in the cycle after the taking edge.
  task cmd(input logic [7:0] b);
    ctl_u.send(b, 1'b1);
    @(negedge clk);
  endtask : cmd
  task offer(input logic qry);
    @(posedge clk);
    dev_cmd_valid <= 1'b1;
    dev_cmd_query <= qry;
    @(posedge clk);
    dev_cmd_valid <= 1'b0;
    @(negedge clk);
  endtask : offer
  task talk(input logic [7:0] b);
    @(posedge clk);
    talk_req <= 1'b1;
    outbuf_byte <= b;
    @(posedge clk);
    talk_req <= 1'b0;
    outbuf_byte <= ~b;
    @(negedge clk);
  endtask : talk
  task fp(input logic key);
    @(posedge clk);
    if (key) fp_setting_key <= 1'b1; else fp_entry_done <= 1'b1;
    @(posedge clk);
    fp_setting_key <= 1'b0;
    fp_entry_done <= 1'b0;
    @(negedge clk);
  endtask : fp
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_addr();
    av(1'b0, REG_CONFIG, 32'h0);
    chk(q, {27'h0, RST_PRIM_ADDR});
    av(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    ctl_u.send(MLA, 1'b0);
    @(negedge clk);
    chk(listener_active, 1'b0);
    cmd({1'b1, MLA[6:0]});
    chk({addressed_indicator, remote_indicator, listener_active}, 3'b111);
    cmd(MTA);
    chk({talker_active, listener_active}, 2'b10);
    cmd(MLA);
    chk({talker_active, listener_active}, 2'b01);
    cmd(CODE_UNL);
    chk({addressed_indicator, listener_active}, 2'b00);
    offer(1'b0);
    chk({cmd_exec, cmd_error}, 2'b00);
    $display("t_addr done");
  endtask : t_addr
  task t_poll();
    av(1'b1, REG_POLL_BYTE, 32'h45);
    repeat (2) @(negedge clk);
    chk(srq, 1'b1);
    cmd(MTA);
    cmd(CODE_SPE);
    talk(8'h33);
    chk({talk_valid, talk_byte}, 9'h145);
    cmd(CODE_SPD);
    talk(8'h33);
    chk({talk_valid, talk_byte}, 9'h133);
    cmd(CODE_UNT);
    talk(8'h5a);
    chk(talk_valid, 1'b0);
    $display("t_poll done");
  endtask : t_poll
  task t_clear_single_triggered_mode();
    cmd(CODE_SDC);
    chk(dev_clear, 1'b0);
    cmd(CODE_DCL);
    chk(dev_clear, 1'b1);
    for (int m = 0; m < 5; m++) begin
      av(1'b1, REG_CONFIG, {24'h0, m < 4, 2'(m), 5'h07});
      cmd(8'h27);
      chk(listener_active, 1'b1);
      cmd(CODE_GET);
      chk(dev_trigger, m < 3);
    end
    cmd(CODE_SDC);
    chk(dev_clear, 1'b1);
    av(1'b1, REG_CONFIG, {27'h0, RST_PRIM_ADDR});
    $display("t_clear_single_triggered_mode done");
  endtask : t_clear_single_triggered_mode
  task t_rl();
    cmd(CODE_UNL);
    cmd(CODE_LLO);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, stv(0, 0, 0, remote_state));
    cmd(MLA);
    cmd(CODE_LLO);
    fp(1'b1);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, stv(0, 1, 0, remote_lockout_state));
    offer(1'b0);
    chk({remote_indicator, cmd_exec, cmd_error}, 3'b110);
    cmd(CODE_GTL);
    offer(1'b0);
    chk({remote_indicator, cmd_exec, cmd_error}, 3'b001);
    offer(1'b1);
    chk({cmd_exec, cmd_error}, 2'b10);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, stv(0, 1, 0, local_lockout_state));
    ctl_u.set_ren(1'b0);
    ctl_u.set_ren(1'b1);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, stv(0, 1, 0, local_state));
    // Lockout from plain local; a pending return-to-local must not hold back remote there.
    cmd(CODE_LLO);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, stv(0, 1, 0, local_lockout_state));
    fp(1'b1);
    cmd(MLA);
    chk(remote_indicator, 1'b1);
    fp(1'b0);
    ctl_u.set_ren(1'b0);
    ctl_u.set_ren(1'b1);
    cmd(MLA);
    dev_pending <= 1'b1;
    fp(1'b1);
    chk({remote_indicator, rtl_error}, 2'b01);
    dev_pending <= 1'b0;
    cmd(MLA);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, stv(0, 1, 1, local_state));
    repeat (TMO) @(posedge clk);
    cmd(MLA);
    chk(remote_indicator, 1'b1);
    fp(1'b1);
    chk(rtl_error, 1'b0);
    fp(1'b0);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, stv(0, 1, 0, local_state));
    cmd(MTA);
    ctl_u.pulse_ifc();
    @(negedge clk);
    chk({talker_active, listener_active, addressed_indicator}, 3'b000);
    $display("t_rl done");
  endtask : t_rl
  // Reset is held for 12 cycles, then the scenarios run in turn.
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_addr();
    t_poll();
    t_clear_single_triggered_mode();
    t_rl();
    test_done();
  end
endmodule : testbench
